// >>> design/general_purpose_timer_two.sv
// General purpose 16-bit up/down timer with Wishbone register access
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "timer_consts.svh"

module general_purpose_timer_two (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic sys_clk_en,
  input wire logic system_clock_config_hf,
  input wire logic low_frequency_oscillator,
  input wire logic hf_oscillator,
  input wire logic hf_crystal,
  input wire logic [15:0] snapshot_event,
  output logic irq
);

  // Pin synchronisers: first stage read only by second
  logic [18:0] pin_s1_r;
  logic [18:0] pin_s2_r;
  logic [18:0] pin_s3_r;
  logic [18:0] pin_rise;

  genvar gi;
  generate
    for (gi = 0; gi < `TMR_PIN_LINES; gi = gi + 1) begin : g_sync
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          pin_s1_r[gi] <= 1'b0;
          pin_s2_r[gi] <= 1'b0;
          pin_s3_r[gi] <= 1'b0;
        end else begin
          pin_s1_r[gi] <= (gi < 16) ? snapshot_event[gi % 16] :
                          (gi == 16) ? low_frequency_oscillator :
                          (gi == 17) ? hf_oscillator : hf_crystal;
          pin_s2_r[gi] <= pin_s1_r[gi];
          pin_s3_r[gi] <= pin_s2_r[gi];
        end
      end
      assign pin_rise[gi] = pin_s2_r[gi] & ~pin_s3_r[gi];
    end
  endgenerate

  function automatic timer_pkg::sync_e sync_step(timer_pkg::sync_e st, logic start);
    timer_pkg::sync_e nx;
    nx = st;
    case (st)
      timer_pkg::sy_idle: nx = start ? timer_pkg::sy_one : timer_pkg::sy_idle;
      timer_pkg::sy_one: nx = timer_pkg::sy_two;
      timer_pkg::sy_two: nx = start ? timer_pkg::sy_one : timer_pkg::sy_idle;
      default: nx = timer_pkg::sy_idle;
    endcase
    return nx;
  endfunction

  // Register side state
  timer_pkg::ctl_s ctl_r, ctl_nxt;
  timer_pkg::sync_e ctl_sy_r, ctl_sy_nxt;
  timer_pkg::sync_e clr_sy_r, clr_sy_nxt;
  logic [15:0] ld_sw_r, ld_sw_nxt;
  logic ld_wait_r, ld_wait_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic req, wr, wr_ctl, wr_clr, wr_load, snap_clr;
  // Timer side state
  timer_pkg::ctl_s act_r, act_nxt;
  logic [15:0] load_r, load_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic started_r, started_nxt;
  logic expired_r, expired_nxt;
  logic [15:0] snap_r, snap_nxt;
  logic snap_pend_r, snap_pend_nxt;
  logic irq_r, irq_nxt;
  logic tick, src_tick, fast_src, load_take, clr_take, timeout_now, ev_hit;
  logic [15:0] start_val, step, term;

  assign req = cyc_i & stb_i & ~ack_r;
  // Writes land at the edge where the master samples ack high
  assign wr = cyc_i & stb_i & ack_r & we_i;
  assign wr_ctl = wr & (adr_i == `TMR_ADR_CTRL) & sel_i[0];
  assign wr_clr = wr & (adr_i == `TMR_ADR_CLEAR) & sel_i[0];
  assign wr_load = wr & (adr_i == `TMR_ADR_LOAD);
  assign snap_clr = wr_clr & dat_i[`TMR_CLR_SNAP_BIT];
  assign clr_take = clr_sy_r == timer_pkg::sy_two;

  always_comb begin
    ctl_nxt = ctl_r;
    ld_sw_nxt = ld_sw_r;
    ld_wait_nxt = ld_wait_r & ~load_take;
    ack_nxt = req;
    dat_nxt = 32'h00000000;
    if (wr_ctl) begin
      ctl_nxt[7:0] = dat_i[7:0];
      if (sel_i[1]) begin
        ctl_nxt[12:8] = dat_i[12:8];
      end
    end
    if (wr_load) begin
      if (sel_i[0]) begin
        ld_sw_nxt[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
        ld_sw_nxt[15:8] = dat_i[15:8];
      end
      ld_wait_nxt = |sel_i[1:0];
    end
    ctl_sy_nxt = sync_step(ctl_sy_r, wr_ctl);
    clr_sy_nxt = sync_step(clr_sy_r, wr_clr & dat_i[`TMR_CLR_EXPIRY_BIT]);
    if (req && !we_i) begin
      case (adr_i)
        `TMR_ADR_LOAD: dat_nxt[15:0] = ld_sw_r;
        `TMR_ADR_VALUE: dat_nxt[15:0] = cnt_r;
        `TMR_ADR_CTRL: dat_nxt[12:0] = ctl_r;
        `TMR_ADR_SNAP: dat_nxt[15:0] = snap_r;
        `TMR_ADR_STAT: begin
          dat_nxt[`TMR_STA_EXPIRY_BIT] = expired_r;
          dat_nxt[`TMR_STA_SNAP_BIT] = snap_pend_r;
          dat_nxt[`TMR_STA_BUSY_BIT] = ctl_sy_r != timer_pkg::sy_idle;
          dat_nxt[`TMR_STA_CLRP_BIT] = clr_sy_r != timer_pkg::sy_idle;
        end
        default: dat_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctl_r <= timer_pkg::ctl_s'(`TMR_CTRL_RESET);
      ctl_sy_r <= timer_pkg::sy_idle;
      clr_sy_r <= timer_pkg::sy_idle;
      ld_sw_r <= 16'h0000;
      ld_wait_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ctl_r <= ctl_nxt;
      ctl_sy_r <= ctl_sy_nxt;
      clr_sy_r <= clr_sy_nxt;
      ld_sw_r <= ld_sw_nxt;
      ld_wait_r <= ld_wait_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // Clock source selection
  always_comb begin
    case (act_r.clk_select)
      timer_pkg::src_bus: src_tick = 1'b1;
      timer_pkg::src_sys: src_tick = sys_clk_en;
      timer_pkg::src_lf: src_tick = pin_rise[16];
      default: src_tick = system_clock_config_hf ? pin_rise[18] : pin_rise[17];
    endcase
  end
  assign fast_src = (act_r.clk_select == timer_pkg::src_bus) ||
                    (act_r.clk_select == timer_pkg::src_sys);

  timer_prescaler u_prescaler (
    .mclk(mclk),
    .resetn(resetn),
    .run(act_r.enable & started_r),
    .src_tick(src_tick),
    .fast_src(fast_src),
    .prescale(act_r.prescale),
    .tick_o(tick)
  );

  always_comb begin
    start_val = act_r.run_style_select ? load_r :
                (act_r.count_up ? `TMR_COUNT_ZERO : `TMR_COUNT_FULL);
    term = act_r.count_up ? `TMR_COUNT_FULL : `TMR_COUNT_ZERO;
    step = act_r.count_up ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
    timeout_now = act_r.enable & started_r & tick & (step == term);
    load_take = ld_wait_r & ~timeout_now;
    ev_hit = act_r.snapshot_trigger_allow & pin_rise[act_r.event_select];
  end

  always_comb begin
    act_nxt = (ctl_sy_r == timer_pkg::sy_two) ? ctl_r : act_r;
    load_nxt = load_take ? ld_sw_r : load_r;
    cnt_nxt = cnt_r;
    started_nxt = started_r;
    expired_nxt = expired_r;
    snap_nxt = snap_r;
    snap_pend_nxt = snap_pend_r & ~snap_clr;
    if (!act_r.enable) begin
      cnt_nxt = `TMR_COUNT_ZERO;
      started_nxt = 1'b0;
    end else if (!started_r) begin
      cnt_nxt = start_val;
      started_nxt = 1'b1;
    end else if (timeout_now) begin
      cnt_nxt = start_val;
    end else if (clr_take && act_r.run_style_select && act_r.clear_restarts_counter) begin
      cnt_nxt = load_r;
    end else if (tick) begin
      cnt_nxt = step;
    end
    if (clr_take) begin
      expired_nxt = 1'b0;
    end
    if (timeout_now) begin
      expired_nxt = 1'b1;
    end
    if (ev_hit && !snap_pend_r) begin
      snap_nxt = cnt_r;
      snap_pend_nxt = 1'b1;
    end
    irq_nxt = expired_nxt | snap_pend_nxt;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      act_r <= timer_pkg::ctl_s'(`TMR_CTRL_RESET);
      load_r <= 16'h0000;
      cnt_r <= 16'h0000;
      started_r <= 1'b0;
      expired_r <= 1'b0;
      snap_r <= 16'h0000;
      snap_pend_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      act_r <= act_nxt;
      load_r <= load_nxt;
      cnt_r <= cnt_nxt;
      started_r <= started_nxt;
      expired_r <= expired_nxt;
      snap_r <= snap_nxt;
      snap_pend_r <= snap_pend_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign irq = irq_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_disable_clears;
    !act_r.enable |=> cnt_r == 16'h0000;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("count not cleared");

  property p_periodic_start;
    act_r.enable && !started_r && act_r.run_style_select |=> cnt_r == $past(load_r);
  endproperty
  a_periodic_start: assert property (p_periodic_start) else $error("bad periodic start");

  property p_free_start;
    act_r.enable && !started_r && !act_r.run_style_select
      |=> cnt_r == ($past(act_r.count_up) ? 16'h0000 : 16'hffff);
  endproperty
  a_free_start: assert property (p_free_start) else $error("bad free start");

  property p_count_down;
    act_r.enable && started_r && tick && !act_r.count_up && !timeout_now && !clr_take
      |=> cnt_r == $past(cnt_r) - 16'h0001;
  endproperty
  a_count_down: assert property (p_count_down) else $error("bad decrement");

  property p_expiry_clear;
    wr_clr && dat_i[0] ##1 (!timeout_now)[*2] |=> !expired_r;
  endproperty
  a_expiry_clear: assert property (p_expiry_clear) else $error("expiry not cleared");

  property p_zero_no_effect;
    wr_clr && !dat_i[0] && clr_sy_r == timer_pkg::sy_idle |=> clr_sy_r == timer_pkg::sy_idle;
  endproperty
  a_zero_no_effect: assert property (p_zero_no_effect) else $error("zero write acted");

  property p_snapshot_hold;
    snap_pend_r && !snap_clr |=> $stable(snap_r);
  endproperty
  a_snapshot_hold: assert property (p_snapshot_hold) else $error("snapshot overwritten");

  property p_clear_pending;
    wr_clr && dat_i[0] |=> clr_sy_r != timer_pkg::sy_idle ##1 clr_sy_r == timer_pkg::sy_two;
  endproperty
  a_clear_pending: assert property (p_clear_pending) else $error("clear flag wrong");

  property p_busy_apply;
    wr_ctl ##1 (!wr_ctl)[*2] |=> act_r == $past(ctl_r) && ctl_sy_r == timer_pkg::sy_idle;
  endproperty
  a_busy_apply: assert property (p_busy_apply) else $error("control not applied");

  property p_expiry_set;
    timeout_now |=> expired_r && irq;
  endproperty
  a_expiry_set: assert property (p_expiry_set) else $error("expiry not flagged");

  property p_load_defer;
    ld_wait_r && timeout_now && !wr_load |=> ld_wait_r && load_r == $past(load_r);
  endproperty
  a_load_defer: assert property (p_load_defer) else $error("load not deferred");

  c_timeout: cover property (timeout_now);
  c_snapshot: cover property (ev_hit && !snap_pend_r);
  c_busy: cover property (wr_ctl ##1 ctl_sy_r != timer_pkg::sy_idle);
  c_restart: cover property (clr_take && act_r.clear_restarts_counter);

endmodule // general_purpose_timer_two

// >>> design/timer_consts.svh
// Register addresses, field positions, reset values and counts of the timer
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

`define TMR_ADR_LOAD 32'h40000800
`define TMR_ADR_VALUE 32'h40000804
`define TMR_ADR_CTRL 32'h40000808
`define TMR_ADR_CLEAR 32'h4000080c
`define TMR_ADR_SNAP 32'h40000810
`define TMR_ADR_STAT 32'h4000081c

`define TMR_CTRL_RESET 13'h000a
`define TMR_CTRL_WIDTH 13

`define TMR_CLR_EXPIRY_BIT 0
`define TMR_CLR_SNAP_BIT 1
`define TMR_STA_EXPIRY_BIT 0
`define TMR_STA_SNAP_BIT 1
`define TMR_STA_BUSY_BIT 6
`define TMR_STA_CLRP_BIT 7

`define TMR_COUNT_ZERO 16'h0000
`define TMR_COUNT_FULL 16'hffff

`define TMR_DIV1_LAST 15'h0000
`define TMR_DIV4_LAST 15'h0003
`define TMR_DIV16_LAST 15'h000f
`define TMR_DIV256_LAST 15'h00ff
`define TMR_DIV32768_LAST 15'h7fff

`define TMR_EVENT_LINES 16
`define TMR_PIN_LINES 19

`endif

// >>> design/timer_pkg.sv
// Types used by the general_purpose_timer_two design file
package timer_pkg;

  typedef enum logic [1:0] {
    src_bus,
    src_sys,
    src_lf,
    src_hf
  } src_e;

  typedef enum logic [1:0] {
    sy_idle,
    sy_one,
    sy_two
  } sync_e;

  typedef struct packed {
    logic snapshot_trigger_allow;
    logic [3:0] event_select;
    logic clear_restarts_counter;
    src_e clk_select;
    logic enable;
    logic run_style_select;
    logic count_up;
    logic [1:0] prescale;
  } ctl_s;

endpackage

// >>> design/timer_prescaler.sv
// Prescaler turning source ticks into counter enable pulses
`timescale 1ns/1ps
`include "timer_consts.svh"

module timer_prescaler (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic run,
  input wire logic src_tick,
  input wire logic fast_src,
  input wire logic [1:0] prescale,
  output logic tick_o
);

  logic [14:0] div_r;
  logic [14:0] div_nxt;
  logic tick_r;
  logic tick_nxt;
  logic [14:0] last;

  always_comb begin
    case (prescale)
      2'h0: last = fast_src ? `TMR_DIV4_LAST : `TMR_DIV1_LAST;
      2'h1: last = `TMR_DIV16_LAST;
      2'h2: last = `TMR_DIV256_LAST;
      default: last = `TMR_DIV32768_LAST;
    endcase
    div_nxt = div_r;
    tick_nxt = 1'b0;
    if (!run) begin
      div_nxt = 15'h0000;
    end else if (src_tick) begin
      if (div_r >= last) begin
        div_nxt = 15'h0000;
        tick_nxt = 1'b1;
      end else begin
        div_nxt = div_r + 15'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 15'h0000;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule // timer_prescaler

// >>> sim/tb_general_purpose_timer_two.sv
// Self-checking testbench for the general purpose timer
`timescale 1ns/1ps
`include "timer_consts.svh"

module tb_general_purpose_timer_two;
  logic mclk = 1'b0;
  logic resetn, cyc_i, stb_i, we_i, ack_o, irq, sys_clk_en, system_clock_config_hf;
  logic low_frequency_oscillator, hf_oscillator, hf_crystal;
  logic [31:0] adr_i, dat_i, dat_o;
  logic [3:0] sel_i;
  logic [15:0] snapshot_event, v, s1, s2;
  int bad_count = 0;
  int n_checks = 0;
  int ph = 0;
  localparam logic [31:0] rst_adr[6] = '{`TMR_ADR_LOAD, `TMR_ADR_VALUE, `TMR_ADR_CTRL,
    `TMR_ADR_SNAP, `TMR_ADR_STAT, 32'h40000818};
  localparam logic [15:0] rst_val[6] = '{16'h0000, 16'h0000, 16'h000a, 16'h0000,
    16'h0000, 16'h0000};
  localparam int src_lo[5] = '{98, 31, 48, 64, 38};
  localparam int src_hi[5] = '{103, 36, 53, 70, 43};
  localparam int pre_wait[3] = '{160, 2560, 33000};
  localparam int pre_lo[3] = '{9, 9, 1};
  localparam int pre_hi[3] = '{11, 11, 2};

  general_purpose_timer_two uut (.mclk(mclk), .resetn(resetn), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .sys_clk_en(sys_clk_en),
    .system_clock_config_hf(system_clock_config_hf),
    .low_frequency_oscillator(low_frequency_oscillator), .hf_oscillator(hf_oscillator),
    .hf_crystal(hf_crystal), .snapshot_event(snapshot_event), .irq(irq));

  always #25 mclk = ~mclk;

  // Slow source clocks, all slower than mclk/2
  always @(posedge mclk) begin
    ph <= ph + 1;
    sys_clk_en <= (ph % 3 == 0);
    low_frequency_oscillator <= ph[2];
    hf_oscillator <= (ph % 6) < 3;
    hf_crystal <= (ph % 10) < 5;
  end

  task end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task ckr(string nm, logic [31:0] lo, logic [31:0] hi, logic [31:0] g);
    logic ok;
    n_checks++;
    ok = (g >= lo) && (g <= hi);
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %s expected %0h..%0h seen %0h", nm, lo, hi, g);
    end
  endtask

  // One classic cycle, held until ack is sampled high
  task xfer(input logic w, input logic [31:0] a, input logic [15:0] d,
            output logic [15:0] q);
    int n;
    @(posedge mclk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack_o !== 1'b1);
    q = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    chk("ack latency", 32'h2, n);
  endtask

  task wr(input logic [31:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task rd(input logic [31:0] a, output logic [15:0] q);
    xfer(1'b0, a, 16'h0000, q);
  endtask

  task idle();
    logic [15:0] s;
    int n;
    n = 0;
    do begin
      rd(`TMR_ADR_STAT, s);
      n++;
    end while (s[7:6] !== 2'b00 && n < 20);
    chk("busy", 2'b00, s[7:6]);
    chk("busy seen", 32'h2, n);
  endtask

  task stop();
    wr(`TMR_ADR_CTRL, 16'h0008);
    idle();
  endtask

  function automatic logic [15:0] cv(int src, int en, int per, int up, int pre);
    return 16'(src * 32 + en * 16 + per * 8 + up * 4 + pre);
  endfunction

  task measure(input logic [15:0] c, input int w, input int lo, input int hi);
    logic [15:0] a;
    logic [15:0] b;
    wr(`TMR_ADR_CTRL, c);
    idle();
    rd(`TMR_ADR_VALUE, a);
    repeat (w) @(posedge mclk);
    rd(`TMR_ADR_VALUE, b);
    ckr("free start", 32'hf000, 32'hffff, a);
    ckr("ticks", lo, hi, a - b);
    stop();
  endtask

  task pulse(int i);
    @(posedge mclk);
    snapshot_event[i] <= 1'b1;
    repeat (4) @(posedge mclk);
    snapshot_event[i] <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  task t_reset();
    for (int i = 0; i < 6; i++) begin
      rd(rst_adr[i], v);
      chk("reset value", rst_val[i], v);
    end
    wr(`TMR_ADR_VALUE, 16'h1234);
    rd(`TMR_ADR_VALUE, v);
    chk("read only count", 16'h0000, v);
    $display("test reset done");
  endtask

  task t_periodic();
    wr(`TMR_ADR_LOAD, 16'h0010);
    wr(`TMR_ADR_CTRL, cv(0, 1, 1, 0, 0));
    idle();
    repeat (30) @(posedge mclk);
    rd(`TMR_ADR_STAT, v);
    chk("early expiry", 1'b0, v[0]);
    repeat (40) @(posedge mclk);
    rd(`TMR_ADR_STAT, v);
    chk("expiry", 1'b1, v[0]);
    chk("irq", 1'b1, irq);
    rd(`TMR_ADR_VALUE, v);
    ckr("reload", 32'h1, 32'h10, v);
    stop();
    rd(`TMR_ADR_VALUE, v);
    chk("disabled count", 16'h0000, v);
    wr(`TMR_ADR_CLEAR, 16'h0000);
    rd(`TMR_ADR_STAT, v);
    chk("clear zero", 1'b1, v[0]);
    wr(`TMR_ADR_CLEAR, 16'h0001);
    idle();
    rd(`TMR_ADR_STAT, v);
    chk("clear one", 1'b0, v[0]);
    chk("irq low", 1'b0, irq);
    wr(`TMR_ADR_LOAD, 16'hfff0);
    wr(`TMR_ADR_CTRL, cv(0, 1, 1, 1, 0));
    idle();
    repeat (80) @(posedge mclk);
    rd(`TMR_ADR_STAT, v);
    chk("up expiry", 1'b1, v[0]);
    rd(`TMR_ADR_VALUE, v);
    ckr("up reload", 32'hfff0, 32'hfffe, v);
    stop();
    wr(`TMR_ADR_CLEAR, 16'h0001);
    idle();
    $display("test periodic done");
  endtask

  task t_clocks();
    for (int i = 0; i < 5; i++) begin
      system_clock_config_hf <= (i == 4);
      measure(cv(i < 4 ? i : 3, 1, 0, 0, 0), 400, src_lo[i], src_hi[i]);
    end
    for (int p = 1; p < 4; p++)
      measure(cv(0, 1, 0, 0, p), pre_wait[p-1], pre_lo[p-1], pre_hi[p-1]);
    $display("test clocks done");
  endtask

  task t_reload();
    wr(`TMR_ADR_LOAD, 16'h1000);
    wr(`TMR_ADR_CTRL, cv(0, 1, 1, 0, 0) | 16'h0080);
    idle();
    repeat (200) @(posedge mclk);
    wr(`TMR_ADR_CLEAR, 16'h0001);
    idle();
    rd(`TMR_ADR_VALUE, v);
    ckr("restart", 32'h0ff8, 32'h1000, v);
    stop();
    $display("test reload done");
  endtask

  task t_snapshot();
    wr(`TMR_ADR_CTRL, cv(0, 1, 0, 1, 0) | 16'h1500);
    idle();
    pulse(3);
    rd(`TMR_ADR_STAT, v);
    chk("other line", 1'b0, v[1]);
    pulse(5);
    rd(`TMR_ADR_STAT, v);
    chk("pending", 1'b1, v[1]);
    chk("irq snap", 1'b1, irq);
    rd(`TMR_ADR_SNAP, s1);
    ckr("snap", 32'h1, 32'h40, s1);
    repeat (40) @(posedge mclk);
    pulse(5);
    rd(`TMR_ADR_SNAP, v);
    chk("snap held", s1, v);
    wr(`TMR_ADR_CLEAR, 16'h0000);
    rd(`TMR_ADR_STAT, v);
    chk("snap clear zero", 1'b1, v[1]);
    wr(`TMR_ADR_CLEAR, 16'h0002);
    rd(`TMR_ADR_STAT, v);
    chk("snap clear one", 1'b0, v[1]);
    chk("irq off", 1'b0, irq);
    pulse(5);
    rd(`TMR_ADR_SNAP, s2);
    ckr("snap again", s1 + 1, s1 + 16'h40, s2);
    stop();
    wr(`TMR_ADR_CLEAR, 16'h0002);
    $display("test snapshot done");
  endtask

  initial begin
    #3000000;
    bad_count++;
    end_sim();
  end

  initial begin
    resetn = 1'b0;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 32'h00000000;
    dat_i = 32'h00000000;
    sel_i = 4'hf;
    snapshot_event = 16'h0000;
    sys_clk_en = 1'b0;
    system_clock_config_hf = 1'b0;
    low_frequency_oscillator = 1'b0;
    hf_oscillator = 1'b0;
    hf_crystal = 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_periodic();
    t_reload();
    t_snapshot();
    t_clocks();
    end_sim();
  end
endmodule // tb_general_purpose_timer_two
